//--- acs_device.sv
// Device end: serial register port, sync alignment, overrange and sleep control.
`timescale 1ns/1ns
`default_nettype none
module acs_device (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Link pins from the host
  acs_link_if.device                       link,
  // Converter samples
  input  wire logic                        sample_valid,
  input  wire logic signed [11:0]          sample_a,
  // Encoder word stream
  output logic                             enc_valid,
  input  wire logic                        enc_ready,
  output logic [acs_pkg::WORD_BITS-1:0]    enc_word,
  // Sleep pin, doubling as overrange output
  input  wire logic                        power_down_pin_in,
  output logic                             power_down_pin_out,
  output logic                             power_down_pin_oe,
  // Serial readback pin used as overrange output
  output logic                             serial_data_out,
  output logic                             serial_data_out_oe,
  // Status and power controls
  output logic                             fast_overrange_flag,
  output logic                             multiframe_edge,
  output logic                             timing_valid,
  output logic                             global_sleep,
  output logic                             link_sleep,
  output logic                             converter_a_sleep,
  output logic                             converter_b_sleep,
  output logic                             input_buffer_a_sleep,
  output logic                             input_buffer_b_sleep
);
  import acs_pkg::*;

  logic [2:0]  sclk_sync, sen_sync, sdi_sync, sys_sync;
  logic [FRAME_BITS-1:0] shift;
  logic [4:0]  bit_cnt;
  logic        frame_done;
  logic [7:0]  page;
  logic [7:0]  mask1_adc, mask1_buf, mask2_adc, mask2_buf, sleep_cfg;
  logic [7:0]  sync_reg, manual_en, mask_en, thresh, route, fpmf;
  acs_lane_t   lane_cfg;
  logic        sync_event;
  logic [1:0]  quarter_cnt;
  logic [4:0]  frame_cnt;
  logic [OVR_LATENCY-1:0] ovr_pipe;
  logic [19:0] level_scaled;
  logic [11:0] magnitude;
  logic        pin_sleep;
  logic        next_in_valid;
  logic [WORD_BITS-1:0] next_word;
  logic        fifo_ready;

  // Two-stage synchronisers; stage 1 and later only, stage 0 is never read.
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_sync <= '0;
      sen_sync  <= 3'h7;
      sdi_sync  <= '0;
      sys_sync  <= '0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], link.serial_clk};
      sen_sync  <= {sen_sync[1:0], link.serial_enable_n};
      sdi_sync  <= {sdi_sync[1:0], link.serial_data_in};
      sys_sync  <= {sys_sync[1:0], link.sync_pulse};
    end
  end

  // Shift on each serial clock rise while enable is low. [R20]
  always_ff @(posedge clk) begin
    if (rst || sen_sync[1]) begin
      bit_cnt <= '0;
      shift   <= '0;
    end else if (sclk_sync[1] && !sclk_sync[2]) begin
      shift   <= {shift[FRAME_BITS-2:0], sdi_sync[1]};
      bit_cnt <= (bit_cnt == 5'(FRAME_BITS)) ? 5'd1 : bit_cnt + 5'd1;
    end
  end

  // A frame completes at every 24th bit; a longer frame writes its first 24 bits, then again at each further multiple of 24. [R19]
  assign frame_done = !sen_sync[1] && sclk_sync[2] && !sclk_sync[1] &&
                      bit_cnt == 5'(FRAME_BITS);

  // Register writes, decoded by page; the write bit must be zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      page      <= RST_ZERO;
      mask1_adc <= RST_ZERO;
      mask1_buf <= RST_ZERO;
      mask2_adc <= RST_ZERO;
      mask2_buf <= RST_ZERO;
      sleep_cfg <= RST_ZERO;
      sync_reg  <= RST_ZERO;
      manual_en <= RST_ZERO;
      mask_en   <= RST_ZERO;
      thresh    <= RST_THRESH; // [R14]
      route     <= RST_ZERO;
      lane_cfg  <= ACS_LANE_8224;
      fpmf      <= RST_FPMF;
    end else if (frame_done && !shift[FRAME_BITS-1]) begin
      if (shift[23:8] == PAGE_SEL_ADDR || shift[23:8] == JESD_PAGE_ADDR) begin
        page <= shift[7:0]; // [R19]
      end else if (page == PAGE_MASTER && shift[22:16] == '0) begin
        unique case (shift[15:8])
          OFS_MASK1_ADC:  mask1_adc <= shift[7:0];
          OFS_MASK1_BUF:  mask1_buf <= shift[7:0];
          OFS_MASK2_ADC:  mask2_adc <= shift[7:0];
          OFS_MASK2_BUF:  mask2_buf <= shift[7:0];
          OFS_SLEEP_CFG:  sleep_cfg <= shift[7:0];
          OFS_SYNC_PULSE: sync_reg  <= shift[7:0];
          OFS_MANUAL_EN:  manual_en <= shift[7:0];
          OFS_SLEEP_MEN:  mask_en   <= shift[7:0];
          OFS_OVR_THRESH: thresh    <= shift[7:0];
          OFS_OVR_ROUTE:  route     <= shift[7:0];
          OFS_LANE_CFG:   lane_cfg  <= acs_lane_t'(shift[LANE_CFG_BITS-1:0]);
          default:        ;
        endcase
      end else if (page == PAGE_JESD_DIG && shift[15:8] == OFS_FPMF) begin
        fpmf <= shift[7:0]; // [R4]
      end
    end
  end

  // Manual level rising edge counts as a sync event like the pin. [R7] [R23]
  logic manual_lvl, manual_lvl_d;
  assign manual_lvl = manual_en[BIT_MANUAL_EN] && sync_reg[BIT_MANUAL_LVL];
  always_ff @(posedge clk) begin
    if (rst) begin
      manual_lvl_d <= 1'b0;
    end else begin
      manual_lvl_d <= manual_lvl;
    end
  end
  // The mask bit blocks the external pin but not the manual source.
  assign sync_event = (sys_sync[1] && !sys_sync[2] && !sync_reg[BIT_SYNC_MASK]) ||
                      (manual_lvl && !manual_lvl_d); // [R1] [R23]

  // Multiframe counters start only after the first sync event. [R6]
  always_ff @(posedge clk) begin
    if (rst) begin
      timing_valid <= 1'b0;
    end else if (sync_event) begin
      timing_valid <= 1'b1; // [R6]
    end
  end

  always_ff @(posedge clk) begin
    if (rst || sync_event) begin
      quarter_cnt     <= '0; // [R1] [R6]
      frame_cnt       <= '0;
      multiframe_edge <= sync_event;
    end else if (timing_valid) begin
      multiframe_edge <= 1'b0;
      // Frame tick is every clock for 4211, every fourth clock otherwise. [R3]
      if (lane_cfg == ACS_LANE_4211 || quarter_cnt == 2'd3) begin
        if (frame_cnt == fpmf[FPMF_MSB:0]) begin // [R4]
          frame_cnt       <= '0;
          multiframe_edge <= 1'b1;
        end else begin
          frame_cnt <= frame_cnt + 5'd1;
        end
      end
      quarter_cnt <= quarter_cnt + 2'd1;
    end else begin
      multiframe_edge <= 1'b0;
    end
  end

  // Trip level compares magnitude*255 against full scale*threshold. [R13]
  assign magnitude    = sample_a[11] ? 12'(-sample_a) : 12'(sample_a);
  assign level_scaled = 20'(FULL_SCALE) * 20'(thresh);
  always_ff @(posedge clk) begin
    if (rst) begin
      ovr_pipe <= '0;
    end else begin
      ovr_pipe <= {ovr_pipe[OVR_LATENCY-2:0],
                   sample_valid && (20'(magnitude) * 20'(THRESH_DIV) > level_scaled)}; // [R12]
    end
  end
  assign fast_overrange_flag = ovr_pipe[OVR_LATENCY-1]; // [R12]

  // Encoder word: sample in upper bits, zeros or flag below. [R10] [R11]
  assign next_in_valid = sample_valid && !global_sleep;
  assign next_word     = {sample_a, 3'h0,
                          route[BIT_OVR_STREAM] & fast_overrange_flag}; // [R10] [R11]

  acs_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) acs_fifo_i (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (next_in_valid),
    .in_ready  (fifo_ready),
    .in_data   (next_word),
    .out_valid (enc_valid),
    .out_ready (enc_ready),
    .out_data  (enc_word)
  );

  // Spare pins carry the flag when routed there. [R9]
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_data_out    <= 1'b0;
      power_down_pin_out <= 1'b0;
    end else begin
      serial_data_out    <= fast_overrange_flag;
      power_down_pin_out <= fast_overrange_flag;
    end
  end
  assign serial_data_out_oe = route[BIT_OVR_PINS]; // [R9]
  assign power_down_pin_oe  = route[BIT_OVR_PINS];

  // Sleep: pin is ignored while it serves as output or when overridden. [R15]
  logic [1:0] pdn_sync;
  always_ff @(posedge clk) begin
    if (rst) begin
      pdn_sync <= '0;
    end else begin
      pdn_sync <= {pdn_sync[0], power_down_pin_in};
    end
  end
  assign pin_sleep = pdn_sync[1] && !route[BIT_OVR_PINS] && !sleep_cfg[BIT_PIN_OVR];

  logic [7:0] sel_adc, sel_buf;
  logic       masked;
  always_ff @(posedge clk) begin
    if (rst) begin
      global_sleep         <= 1'b0;
      link_sleep           <= 1'b0;
      converter_a_sleep    <= 1'b0;
      converter_b_sleep    <= 1'b0;
      input_buffer_a_sleep <= 1'b0;
      input_buffer_b_sleep <= 1'b0;
    end else begin
      global_sleep         <= sleep_cfg[BIT_GLOBAL] || (pin_sleep && !masked); // [R15] [R17]
      link_sleep           <= sleep_cfg[BIT_GLOBAL] || (pin_sleep && !masked); // [R17] [R18]
      converter_a_sleep    <= global_sleep || (masked && (|sel_adc[7:4])); // [R18]
      converter_b_sleep    <= global_sleep || (masked && (|sel_adc[3:0]));
      input_buffer_a_sleep <= global_sleep || (masked && (|sel_buf[5:4]));
      input_buffer_b_sleep <= global_sleep || (masked && (|sel_buf[7:6]));
    end
  end
  // Mask selection picks which pair of fields applies. [R16]
  assign sel_adc = sleep_cfg[BIT_MASK_SEL] ? mask2_adc : mask1_adc;
  assign sel_buf = sleep_cfg[BIT_MASK_SEL] ? mask2_buf : mask1_buf;
  assign masked  = mask_en[BIT_MASK_EN]; // [R18]

  logic unused_ok;
  assign unused_ok = fifo_ready;
endmodule : acs_device
`default_nettype wire

//--- acs_pkg.sv
// Package of constants and types shared by the converter control block and its host end.
// Behaviour
// R1: Sample sync pulse, realign multiframe clock boundary.
// R2: Sync pulse is multiframe rate over power-of-two.
// R3: Multiframe rate divides by four except 4211.
// R4: Frames per multiframe is field plus one.
// R5: Sync pulse preferably between 1 and 5 MHz.
// R6: Sync pulse resets timing counters; otherwise uninitialised.
// R7: Manual sync enabled, data bit drives sync.
// R8: Host sends manual sync high-low pair twice.
// R9: Overrange flag in stream or on spare pins.
// R10: Encoder word is 12-bit sample, four zeros.
// R11: In-stream mode replaces word LSB with flag.
// R12: Overrange flag appears 18 cycles after overload; the spare pins here show it after 19.
// R13: Trip level is full scale times field/255.
// R14: Threshold field resets to E3h.
// R15: Sleep from pin or from register writes.
// R16: Two sleep masks, select bit picks one.
// R17: Global sleep bit powers down everything.
// R18: Masked sleep needs enable bit; link stays.
// R19: Frame is 16 address bits, 8 data bits.
// R20: Shift data on serial clock rise while enabled low.
// R21: Host serial clock at most 2 MHz.
// R22: Host selects master page before master writes.
// R23: Manual sync rising edge acts like external edge.
`default_nettype none
package acs_pkg;

  localparam int          FRAME_BITS     = 24;
  localparam int          ADDR_BITS      = 16;
  localparam int          DATA_BITS      = 8;
  localparam int          SAMPLE_BITS    = 12;
  localparam int          WORD_BITS      = 16;
  localparam int          FIFO_DEPTH     = 8;
  localparam int          OVR_LATENCY    = 18;
  localparam int          LANE_CFG_BITS  = 2;

  // Page select register and page codes.
  localparam logic [15:0] PAGE_SEL_ADDR  = 16'h0011;
  localparam logic [7:0]  PAGE_MASTER    = 8'h80;
  localparam logic [7:0]  PAGE_ADC       = 8'h0F;
  localparam logic [7:0]  PAGE_JESD_DIG  = 8'h69;
  localparam logic [15:0] JESD_PAGE_ADDR = 16'h4004;

  // Master page offsets.
  localparam logic [7:0]  OFS_MASK1_ADC  = 8'h20;
  localparam logic [7:0]  OFS_MASK1_BUF  = 8'h21;
  localparam logic [7:0]  OFS_MASK2_ADC  = 8'h23;
  localparam logic [7:0]  OFS_MASK2_BUF  = 8'h24;
  localparam logic [7:0]  OFS_SLEEP_CFG  = 8'h26;
  localparam logic [7:0]  OFS_SYNC_PULSE = 8'h53;
  localparam logic [7:0]  OFS_MANUAL_EN  = 8'h54;
  localparam logic [7:0]  OFS_SLEEP_MEN  = 8'h55;
  // Block-local master-page offsets for overrange and lane control.
  localparam logic [7:0]  OFS_OVR_THRESH = 8'h5A;
  localparam logic [7:0]  OFS_OVR_ROUTE  = 8'h5B;
  localparam logic [7:0]  OFS_LANE_CFG   = 8'h5C;
  // JESD digital page offset.
  localparam logic [7:0]  OFS_FPMF       = 8'h06;

  // Field positions.
  localparam int          BIT_GLOBAL     = 7;
  localparam int          BIT_PIN_OVR    = 6;
  localparam int          BIT_MASK_SEL   = 5;
  localparam int          BIT_SYNC_MASK  = 6;
  localparam int          BIT_MASK_EN    = 4;
  localparam int          BIT_MANUAL_EN  = 7;
  localparam int          BIT_MANUAL_LVL = 0;
  localparam int          BIT_OVR_STREAM = 0;
  localparam int          BIT_OVR_PINS   = 1;
  localparam int          FPMF_MSB       = 4;

  // Reset values, full scale and threshold divisor.
  localparam logic [7:0]  RST_THRESH     = 8'hE3;
  localparam logic [7:0]  RST_FPMF       = 8'h08;
  localparam logic [7:0]  RST_ZERO       = 8'h00;
  localparam logic [11:0] FULL_SCALE     = 12'h7FF;
  localparam logic [7:0]  THRESH_DIV     = 8'hFF;

  // Lane configurations; only the first one skips the divide by four.
  typedef enum logic [1:0] {
    ACS_LANE_4211  = 2'b00,
    ACS_LANE_4244  = 2'b01,
    ACS_LANE_8224  = 2'b10,
    ACS_LANE_OTHER = 2'b11
  } acs_lane_t;

  // Host timing: half serial period in system clocks, 20 MHz over twice 2 MHz.
  localparam int          CLK_HZ         = 20_000_000;
  localparam int          SCLK_MAX_HZ    = 2_000_000;
  localparam int          HALF_SCLK_CYC  = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);

endpackage : acs_pkg
`default_nettype wire

//--- acs_link_if.sv
// Interface joining the host end and the device end of the serial and sync pins.
`timescale 1ns/1ns
`default_nettype none
interface acs_link_if;
  logic serial_clk;
  logic serial_enable_n;
  logic serial_data_in;
  logic sync_pulse;

  modport host (
    output serial_clk,
    output serial_enable_n,
    output serial_data_in,
    output sync_pulse
  );
  modport device (
    input serial_clk,
    input serial_enable_n,
    input serial_data_in,
    input sync_pulse
  );
endinterface : acs_link_if
`default_nettype wire

//--- acs_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none
module acs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = store[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : acs_fifo
`default_nettype wire

//--- acs_host.sv
// Host end: sends 24-bit serial frames and an optional sync pulse.
`timescale 1ns/1ns
`default_nettype none
module acs_host (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Link pins to the device
  acs_link_if.host                           link,
  // Write command
  input  wire logic                          cmd_valid,
  output logic                               cmd_ready,
  input  wire logic [acs_pkg::ADDR_BITS-1:0] cmd_addr,
  input  wire logic [acs_pkg::DATA_BITS-1:0] cmd_data,
  // External sync level
  input  wire logic                          sync_level
);
  import acs_pkg::*;

  typedef enum logic [1:0] {
    ACS_IDLE  = 2'b00,
    ACS_LOW   = 2'b01,
    ACS_HIGH  = 2'b10,
    ACS_END   = 2'b11
  } acs_host_state_t;

  acs_host_state_t       state;
  logic [FRAME_BITS-1:0] shift;
  logic [4:0]            bits_left;
  logic [3:0]            div_cnt;
  logic                  tick;

  // Half-period enable keeps the serial clock at or below 2 MHz. [R21]
  assign tick      = div_cnt == 4'(HALF_SCLK_CYC - 1);
  assign cmd_ready = state == ACS_IDLE;

  always_ff @(posedge clk) begin
    if (rst || state == ACS_IDLE) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= tick ? '0 : div_cnt + 4'd1;
    end
  end

  // Data changes on the fall, device samples on the rise. [R20]
  always_ff @(posedge clk) begin
    if (rst) begin
      state                <= ACS_IDLE;
      shift                <= '0;
      bits_left            <= '0;
      link.serial_clk      <= 1'b0;
      link.serial_enable_n <= 1'b1;
      link.serial_data_in  <= 1'b0;
    end else begin
      unique case (state)
        ACS_IDLE: if (cmd_valid) begin
          shift                <= {cmd_addr, cmd_data}; // [R19]
          bits_left            <= 5'(FRAME_BITS);
          link.serial_enable_n <= 1'b0;
          link.serial_data_in  <= cmd_addr[ADDR_BITS-1];
          state                <= ACS_LOW;
        end
        ACS_LOW: if (tick) begin
          link.serial_clk <= 1'b1;
          shift           <= {shift[FRAME_BITS-2:0], 1'b0};
          bits_left       <= bits_left - 5'd1;
          state           <= ACS_HIGH;
        end
        ACS_HIGH: if (tick) begin
          link.serial_clk     <= 1'b0;
          link.serial_data_in <= shift[FRAME_BITS-1];
          state               <= (bits_left == '0) ? ACS_END : ACS_LOW;
        end
        ACS_END: if (tick) begin
          link.serial_enable_n <= 1'b1;
          state                <= ACS_IDLE;
        end
      endcase
    end
  end

  // Sync level passes through a register; its rate is the user's duty. [R2] [R5]
  always_ff @(posedge clk) begin
    if (rst) begin
      link.sync_pulse <= 1'b0;
    end else begin
      link.sync_pulse <= sync_level;
    end
  end
endmodule : acs_host
`default_nettype wire

//--- acs_link_checker.sv
// Concurrent checks on the serial wires between the host end and the device end.
`timescale 1ns/1ns
`default_nettype none
module acs_link_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link wires
  input wire logic serial_clk,
  input wire logic serial_enable_n,
  input wire logic serial_data_in,
  input wire logic sync_pulse
);
  logic       clk_q;
  logic [5:0] rise_cnt;
  logic [8:0] frame_cyc;

  // Counters restart whenever the enable is released, so each frame is judged alone.
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= serial_clk;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || serial_enable_n) begin
      rise_cnt  <= 6'h00;
      frame_cyc <= 9'h000;
    end else begin
      rise_cnt  <= rise_cnt + {5'h00, serial_clk & ~clk_q};
      frame_cyc <= frame_cyc + 9'h001;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_sclk_idle_low: assert property (serial_enable_n |-> !serial_clk)
    else $error("serial clock moved outside a frame");
  a_data_held_high: assert property (serial_clk && clk_q |-> $stable(serial_data_in))
    else $error("serial data changed while serial clock high");
  a_sclk_high_width: assert property ($rose(serial_clk) |-> serial_clk[*5] ##1 !serial_clk)
    else $error("serial clock high phase not five cycles");
  a_sclk_low_width: assert property ($fell(serial_clk) |-> !serial_clk[*5])
    else $error("serial clock low phase too short");
  a_enable_setup: assert property ($fell(serial_enable_n) |-> !serial_clk[*2] ##[1:8] serial_clk)
    else $error("enable to first serial clock rise out of range");
  a_enable_hold: assert property ($fell(serial_clk) |-> !serial_enable_n[*2])
    else $error("enable released too soon after serial clock fall");
  a_frame_bits: assert property ($rose(serial_enable_n) |-> rise_cnt == 6'h18)
    else $error("frame did not carry 24 bits");
  a_frame_time: assert property ($rose(serial_enable_n) |-> frame_cyc >= 9'h0F0 && frame_cyc <= 9'h104)
    else $error("frame length out of range");

  c_sync_seen: cover property ($rose(sync_pulse));
endmodule : acs_link_checker
`default_nettype wire

//--- acs_tb.sv
// Self-checking bench for the host end and the device end joined over the serial link.
`timescale 1ns/1ns
`default_nettype none
module acs_tb;
  import acs_pkg::*;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               cmd_valid = 1'b0;
  logic               cmd_ready;
  logic [15:0]        cmd_addr = 16'h0000;
  logic [7:0]         cmd_data = 8'h00;
  logic               sync_level = 1'b0;
  logic               sample_valid = 1'b0;
  logic signed [11:0] sample_a = 12'h000;
  logic               enc_valid, enc_ready = 1'b1;
  logic [15:0]        enc_word;
  logic               pin_in = 1'b0, pin_out, pin_oe, sdo, sdo_oe, flag, mf_edge, tvalid;
  logic               gsl, lsl, cas, cbs, bas, bbs;
  logic [7:0]         cur_thr = 8'hE3;
  int                 n_fail = 0, n_checks = 0, cyc = 0, g, l1, l2;

  acs_link_if link ();
  acs_host acs_host_i (.clk(clk), .rst(rst), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .sync_level(sync_level));
  acs_device acs_device_i (.clk(clk), .rst(rst), .link(link), .sample_valid(sample_valid),
    .sample_a(sample_a), .enc_valid(enc_valid), .enc_ready(enc_ready), .enc_word(enc_word),
    .power_down_pin_in(pin_in), .power_down_pin_out(pin_out), .power_down_pin_oe(pin_oe),
    .serial_data_out(sdo), .serial_data_out_oe(sdo_oe), .fast_overrange_flag(flag),
    .multiframe_edge(mf_edge), .timing_valid(tvalid), .global_sleep(gsl), .link_sleep(lsl),
    .converter_a_sleep(cas), .converter_b_sleep(cbs), .input_buffer_a_sleep(bas),
    .input_buffer_b_sleep(bbs));
  acs_link_checker acs_link_checker_i (.clk(clk), .rst(rst), .serial_clk(link.serial_clk),
    .serial_enable_n(link.serial_enable_n), .serial_data_in(link.serial_data_in),
    .sync_pulse(link.sync_pulse));

  always #25 clk = ~clk;

  // The ceiling leaves about twice the expected run length.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Holds the command until the edge that takes it, then waits for the frame to finish.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    cmd_addr  = a;
    cmd_data  = d;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 800);
    if (cmd_ready !== 1'b1) begin
      n_fail++;
      $display("ERROR at %0t: serial write never finished", $time);
    end
    repeat (4) @(negedge clk);
  endtask : wr

  task automatic mf_gap(output int gap);
    int n;
    n = 0;
    while (mf_edge !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    gap = 0;
    do begin
      @(negedge clk);
      gap++;
    end while (mf_edge !== 1'b1 && gap < 200);
  endtask : mf_gap

  // Latency from a sync pulse to the first multiframe edge seen ten cycles or more later.
  task automatic ext_lat(input int pre, output int lat);
    mf_gap(lat);
    repeat (pre) @(negedge clk);
    sync_level = 1'b1;
    repeat (3) @(negedge clk);
    sync_level = 1'b0;
    repeat (7) @(negedge clk);
    lat = 10;
    while (mf_edge !== 1'b1 && lat < 200) begin
      @(negedge clk);
      lat++;
    end
    if (lat >= 200) begin
      n_fail++;
      $display("ERROR at %0t: no multiframe edge after sync pulse", $time);
    end
  endtask : ext_lat

  task automatic smp(input logic [11:0] v, input int c);
    sample_a     = v;
    sample_valid = 1'b1;
    repeat (c) @(negedge clk);
  endtask : smp

  task automatic ovr_case(input logic [7:0] thr, input logic [11:0] v, input logic exp);
    if (thr !== cur_thr) wr(16'h005A, thr);
    cur_thr = thr;
    smp(v, 30);
    check({15'h0000, flag}, {15'h0000, exp});
  endtask : ovr_case

  task automatic t_sync;
    check({15'h0000, tvalid}, 16'h0000);
    wr(16'h0011, 8'h80);
    wr(16'h0053, 8'h01);
    check({15'h0000, tvalid}, 16'h0000);
    wr(16'h0053, 8'h00);
    wr(16'h0054, 8'h80);
    for (int i = 0; i < 2; i++) begin
      wr(16'h0053, 8'h01);
      check({15'h0000, tvalid}, 16'h0001);
      wr(16'h0053, 8'h00);
    end
    for (int lane = 0; lane < 4; lane++) begin
      wr(16'h005C, 8'(lane));
      mf_gap(g);
      check(16'(g), (lane == 0) ? 16'h0009 : 16'h0024);
    end
    wr(16'h005C, 8'h00);
    wr(16'h4004, 8'h69);
    wr(16'h6006, 8'h03);
    mf_gap(g);
    check(16'(g), 16'h0004);
    wr(16'h6006, 8'h08);
    wr(16'h0011, 8'h80);
    wr(16'h005C, 8'h02);
    ext_lat(3, l1);
    ext_lat(7, l2);
    check(16'(l1), 16'h0028);
    check(16'(l2), 16'(l1));
    wr(16'h0053, 8'h40);
    ext_lat(3, l1);
    ext_lat(7, l2);
    check({15'h0000, l1 != l2}, 16'h0001);
    $display("test sync done");
  endtask : t_sync

  task automatic t_ovr;
    ovr_case(8'hE3, 12'h71E, 1'b0);
    ovr_case(8'hE3, 12'h71F, 1'b1);
    ovr_case(8'hE3, 12'h8E1, 1'b1);
    wr(16'h005B, 8'h01);
    smp(12'h000, 30);
    smp(12'h71F, 17);
    check({15'h0000, flag}, 16'h0000);
    smp(12'h71F, 3);
    check({15'h0000, flag}, 16'h0001);
    smp(12'h71F, 8);
    check({15'h0000, enc_valid}, 16'h0001);
    check(enc_word, 16'h71F1);
    wr(16'h005B, 8'h00);
    check({15'h0000, enc_valid}, 16'h0001);
    check(enc_word, 16'h71F0);
    wr(16'h005B, 8'h02);
    check({12'h000, sdo, sdo_oe, pin_out, pin_oe}, 16'h000F);
    smp(12'h000, 30);
    check({12'h000, sdo, sdo_oe, pin_out, pin_oe}, 16'h0005);
    ovr_case(8'h80, 12'h403, 1'b0);
    ovr_case(8'h80, 12'h404, 1'b1);
    $display("test overrange done");
  endtask : t_ovr

  task automatic t_fifo;
    wr(16'h005B, 8'h00);
    sample_valid = 1'b0;
    repeat (30) @(negedge clk);
    enc_ready = 1'b0;
    for (int i = 0; i < 12; i++) smp(12'(i * 3 + 5), 1);
    sample_valid = 1'b0;
    repeat (30) @(negedge clk);
    enc_ready = 1'b1;
    for (int i = 0; i < 8; i++) begin
      check({15'h0000, enc_valid}, 16'h0001);
      check(enc_word, {12'(i * 3 + 5), 4'h0});
      @(negedge clk);
    end
    check({15'h0000, enc_valid}, 16'h0000);
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_sleep;
    pin_in = 1'b1;
    repeat (8) @(negedge clk);
    check({15'h0000, gsl}, 16'h0001);
    pin_in = 1'b0;
    wr(16'h0026, 8'h80);
    check({14'h0000, gsl, lsl}, 16'h0003);
    wr(16'h0026, 8'h00);
    wr(16'h0020, 8'hF0);
    wr(16'h0021, 8'hC0);
    check({12'h000, cas, cbs, bas, bbs}, 16'h0000);
    wr(16'h0055, 8'h10);
    check({11'h000, lsl, cas, cbs, bas, bbs}, 16'h0009);
    wr(16'h0023, 8'h0F);
    wr(16'h0024, 8'h30);
    wr(16'h0026, 8'h20);
    check({12'h000, cas, cbs, bas, bbs}, 16'h0006);
    $display("test sleep done");
  endtask : t_sleep

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_sync();
    t_ovr();
    t_fifo();
    t_sleep();
    complete_run();
  end
endmodule : acs_tb
`default_nettype wire
